// File: core/ssp_port.sv
// Synchronous serial port with pin muxing, direction control and AXI4-Lite registers
//
// What this block does
// R01: Transmit and receive run at the same time.
// R02: Async mode: control line a is receive clock.
// R03: Sync mode: line a is extra transmitter or flag.
// R04: Async mode: control line b is receive frame sync.
// R05: Sync mode: line b is extra transmitter or flag.
// R06: Frame sync line serves transmitter, receiver when sync.
// R07: Frame sync output drives internal frame sync.
// R08: Input frame sync comes from far party.
// R09: Bit clock serves transmitter, receiver when sync.
// R10: External bit clock at least six phases long.
// R11: Each bit clock half lasts at least three phases.
// R12: Receive data line shifts into receive register.
// R13: Transmit line drives transmit register bits out.
// R14: After reset all pins are general-purpose inputs.
// R15: Per-pin bit picks serial or general use.
// R16: Per-pin bit sets general-purpose direction.
// R17: Stop: inputs ignored, outputs released.
// R18: Wait state leaves pins unchanged.
// R19: External clock and frame sync synchronised first.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssp_port (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Low-power stop state
  input  wire logic        stop_req,
  // AXI4-Lite write address
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Port pins
  input  wire logic [5:0]  pin_i,
  output logic [5:0]       pin_o,
  output logic [5:0]       pin_oe
);
  typedef struct packed {
    logic                      awrdy;
    logic                      wrdy;
    logic                      aw_got;
    logic                      w_got;
    logic [11:0]               awaddr;
    logic [15:0]               wdata;
    logic [1:0]                wstb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arrdy;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic [5:0]                func;
    logic [5:0]                dir;
    logic [5:0]                gpo;
    logic [5:0]                gpi;
    logic [ssp_pkg::CTL_W-1:0] ctrl;
    logic [7:0]                div;
    logic [7:0]                txd;
    logic                      tx_full;
    logic [7:0]                rxd;
    logic                      rx_full;
    logic                      rx_ovr;
    logic [7:0]                hcnt;
    logic                      sck;
    logic [5:0]                prev;
    logic [2:0]                tcnt;
    logic                      fs;
    logic [2:0]                rcnt;
    logic [5:0]                po;
    logic [5:0]                poe;
  } ssp_core_t;

  localparam ssp_core_t RST = '{func: ssp_pkg::FUNC_RST, dir: ssp_pkg::DIR_RST,
                                ctrl: ssp_pkg::CTRL_RST, div: ssp_pkg::DIV_RST, default: '0};

  ssp_core_t   r;
  ssp_core_t   n;
  logic [5:0]  s;
  logic [7:0]  tx_q;
  logic [7:0]  rx_q;
  logic [7:0]  half;
  logic [15:0] wm;
  logic [5:0]  ser_o;
  logic [5:0]  ser_oe;
  logic        tx_load;
  logic        tx_shift;
  logic        rx_shift;
  logic        rx_done;
  logic        int_rise;
  logic        int_fall;
  logic        tx_rise;
  logic        rx_fall;
  logic        tx_start;
  logic        rx_fs;
  logic        din;
  logic        run;
  logic        async_m;
  logic        sck_int;
  logic        fs_int;
  logic        tx_en;
  logic        rx_en;
  logic        a_out;
  logic        b_out;

  assign async_m = r.ctrl[ssp_pkg::CB_ASYNC];
  assign sck_int = r.ctrl[ssp_pkg::CB_SCK_INT];
  assign fs_int  = r.ctrl[ssp_pkg::CB_FS_INT];
  assign tx_en   = r.ctrl[ssp_pkg::CB_TX_EN];
  assign rx_en   = r.ctrl[ssp_pkg::CB_RX_EN];
  assign a_out   = r.ctrl[ssp_pkg::CB_A_OUT];
  assign b_out   = r.ctrl[ssp_pkg::CB_B_OUT];

  function automatic logic rise(input logic p, input logic c);
    return c & ~p;
  endfunction

  function automatic logic fall(input logic p, input logic c);
    return p & ~c;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return (a[1:0] == 2'h0) && (a <= ssp_pkg::OFF_STAT);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] v, input logic [1:0] b);
    return {b[1] ? v[15:8] : o[15:8], b[0] ? v[7:0] : o[7:0]};
  endfunction

  // Pin inputs pass two flops before any edge logic
  ssp_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (pin_i),
    .q       (s)
  ); // R19

  ssp_shifter u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .load    (tx_load),
    .ld_val  (r.txd),
    .shift   (tx_shift),
    .sin     (1'b0),
    .q       (tx_q)
  );

  ssp_shifter u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .load    (1'b0),
    .ld_val  (8'h00),
    .shift   (rx_shift),
    .sin     (din),
    .q       (rx_q)
  );

  always_comb begin
    n        = r;
    wm       = 16'h0000;
    ser_o    = 6'h00;
    ser_oe   = 6'h00;
    tx_load  = 1'b0;
    tx_shift = 1'b0;
    rx_shift = 1'b0;
    rx_done  = 1'b0;
    run      = !stop_req;
    din      = s[ssp_pkg::PIN_RXD];
    n.prev   = s;

    // Divider never goes below the minimum half period, even if software asks
    half = (r.div < ssp_pkg::MIN_HALF) ? ssp_pkg::MIN_HALF : r.div; // R11
    int_rise = (r.hcnt == 8'h00) && !r.sck;
    int_fall = (r.hcnt == 8'h00) && r.sck;
    if (r.hcnt == 8'h00) begin
      n.sck  = ~r.sck;
      n.hcnt = half - 8'h01;
    end else begin
      n.hcnt = r.hcnt - 8'h01;
    end

    // External clock edges rely on the far party keeping halves long enough
    tx_rise = sck_int ? int_rise : rise(r.prev[ssp_pkg::PIN_SCK], s[ssp_pkg::PIN_SCK]); // R09 R10
    if (async_m) begin
      rx_fall = a_out ? int_fall : fall(r.prev[ssp_pkg::PIN_CA], s[ssp_pkg::PIN_CA]); // R02
      rx_fs   = b_out ? r.fs : s[ssp_pkg::PIN_CB]; // R04
    end else begin
      rx_fall = sck_int ? int_fall : fall(r.prev[ssp_pkg::PIN_SCK], s[ssp_pkg::PIN_SCK]); // R09
      rx_fs   = fs_int ? r.fs : s[ssp_pkg::PIN_FS]; // R06 R08
    end
    tx_start = fs_int ? (r.tcnt == 3'h0) : s[ssp_pkg::PIN_FS]; // R06 R08

    // Read channel first, so a word landing now survives a data read
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && r.arrdy) begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(araddr) ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
      case (araddr)
        ssp_pkg::OFF_FUNC: n.rdata = 32'(r.func);
        ssp_pkg::OFF_DIR:  n.rdata = 32'(r.dir);
        ssp_pkg::OFF_GPO:  n.rdata = 32'(r.gpo);
        ssp_pkg::OFF_GPI:  n.rdata = 32'(r.gpi);
        ssp_pkg::OFF_CTRL: n.rdata = 32'(r.ctrl);
        ssp_pkg::OFF_DIV:  n.rdata = 32'(r.div);
        ssp_pkg::OFF_TXD:  n.rdata = 32'(r.txd);
        ssp_pkg::OFF_RXD: begin
          n.rdata   = 32'(r.rxd);
          n.rx_full = 1'b0;
          n.rx_ovr  = 1'b0;
        end
        ssp_pkg::OFF_STAT: n.rdata = 32'({r.rx_ovr, r.rx_full, r.tx_full});
        default:           n.rdata = 32'h0000_0000;
      endcase
    end

    // Transmitter and receiver are independent, so both run at once
    if (!tx_en) begin
      n.tcnt = 3'h0;
      n.fs   = 1'b0;
    end else if (run && tx_rise) begin // R01
      if (tx_start) begin
        tx_load   = 1'b1; // R13
        n.tcnt    = 3'h1;
        n.fs      = fs_int; // R07
        n.tx_full = 1'b0;
      end else if (r.tcnt != 3'h0) begin
        tx_shift = 1'b1; // R13
        n.tcnt   = 3'(r.tcnt + 3'h1);
        n.fs     = 1'b0;
      end
    end

    if (!rx_en) begin
      n.rcnt = 3'h0;
    end else if (run && rx_fall) begin // R01
      if (r.rcnt == ssp_pkg::CNT_LAST) begin
        rx_shift  = 1'b1;
        rx_done   = 1'b1;
        n.rcnt    = 3'h0;
        n.rxd     = {rx_q[ssp_pkg::MSB-1:0], din}; // R12
        n.rx_ovr  = r.rx_ovr | r.rx_full;
        n.rx_full = 1'b1;
      end else if (rx_fs || (r.rcnt != 3'h0)) begin
        rx_shift = 1'b1; // R12
        n.rcnt   = rx_fs && (r.rcnt == 3'h0) ? 3'h1 : 3'(r.rcnt + 3'h1);
      end
    end

    // Write channel last, so a new transmit word beats a load in the same cycle
    if (awvalid && r.awrdy) begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && r.wrdy) begin
      n.w_got = 1'b1;
      n.wdata = wdata[15:0];
      n.wstb  = wstrb[1:0];
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = mapped(r.awaddr) ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
      case (r.awaddr)
        ssp_pkg::OFF_FUNC: begin
          wm     = merge(16'(r.func), r.wdata, r.wstb);
          n.func = wm[5:0]; // R15
        end
        ssp_pkg::OFF_DIR: begin
          wm    = merge(16'(r.dir), r.wdata, r.wstb);
          n.dir = wm[5:0]; // R16
        end
        ssp_pkg::OFF_GPO: begin
          wm    = merge(16'(r.gpo), r.wdata, r.wstb);
          n.gpo = wm[5:0];
        end
        ssp_pkg::OFF_CTRL: begin
          wm     = merge(16'(r.ctrl), r.wdata, r.wstb);
          n.ctrl = wm[ssp_pkg::CTL_W-1:0];
        end
        ssp_pkg::OFF_DIV: begin
          wm    = merge(16'(r.div), r.wdata, r.wstb);
          n.div = wm[7:0];
        end
        ssp_pkg::OFF_TXD: begin
          wm        = merge(16'(r.txd), r.wdata, r.wstb);
          n.txd     = wm[7:0];
          n.tx_full = 1'b1;
        end
        default: wm = 16'h0000;
      endcase
    end
    n.awrdy = !n.aw_got && !n.bvalid;
    n.wrdy  = !n.w_got && !n.bvalid;
    n.arrdy = !n.rvalid;

    // Serial function of each pin; extra transmitters share the main word
    ser_oe[ssp_pkg::PIN_CA] = a_out;
    ser_o[ssp_pkg::PIN_CA]  = async_m ? r.sck // R02
                            : (r.ctrl[ssp_pkg::CB_A_XTX] ? tx_q[ssp_pkg::MSB] : r.ctrl[ssp_pkg::CB_FLAG_A]); // R03
    ser_oe[ssp_pkg::PIN_CB] = b_out;
    ser_o[ssp_pkg::PIN_CB]  = async_m ? r.fs // R04
                            : (r.ctrl[ssp_pkg::CB_B_XTX] ? tx_q[ssp_pkg::MSB] : r.ctrl[ssp_pkg::CB_FLAG_B]); // R05
    ser_oe[ssp_pkg::PIN_FS]  = fs_int; // R07
    ser_o[ssp_pkg::PIN_FS]   = r.fs;
    ser_oe[ssp_pkg::PIN_SCK] = sck_int; // R09
    ser_o[ssp_pkg::PIN_SCK]  = r.sck;
    ser_oe[ssp_pkg::PIN_TXD] = tx_en; // R13
    ser_o[ssp_pkg::PIN_TXD]  = tx_q[ssp_pkg::MSB];

    // Only stop touches the pins; there is no wait input on purpose
    if (stop_req) begin
      n.poe = 6'h00; // R17 R18
    end else begin
      n.po  = (r.func & ser_o) | (~r.func & r.gpo); // R15
      n.poe = (r.func & ser_oe) | (~r.func & r.dir); // R14 R16
      n.gpi = s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= RST; // R14
    end else if (ce) begin
      r <= n;
    end
  end

  assign awready = r.awrdy;
  assign wready  = r.wrdy;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign arready = r.arrdy;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;
  assign pin_o   = r.po;
  assign pin_oe  = r.poe;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_gpio: assert property ($past(!aresetn) |-> r.func == 6'h00 && pin_oe == 6'h00) // R14
    else $error("pins not general-purpose inputs after reset");
  a_gpio_dir: assert property (ce && !stop_req |=> ((pin_oe ^ $past(r.dir)) & ~$past(r.func)) == 6'h00) // R16
    else $error("general-purpose direction mismatch");
  a_gpio_func: assert property (ce && !stop_req |=> ((pin_o ^ $past(r.gpo)) & ~$past(r.func)) == 6'h00) // R15
    else $error("general-purpose output mismatch");
  a_stop_release: assert property (ce && stop_req |=> pin_oe == 6'h00 && $stable(pin_o) && $stable(r.gpi)) // R17
    else $error("stop did not release outputs or freeze inputs");
  a_ctrl_a_async: assert property (ce && !stop_req && r.func[0] && async_m && a_out
                                   |=> pin_oe[0] && pin_o[0] == $past(r.sck)) // R02
    else $error("line a not receive clock in async mode");
  a_ctrl_a_sync: assert property (ce && !stop_req && r.func[0] && !async_m && a_out && !r.ctrl[ssp_pkg::CB_A_XTX]
                                  |=> pin_oe[0] && pin_o[0] == $past(r.ctrl[ssp_pkg::CB_FLAG_A])) // R03
    else $error("line a not flag in sync mode");
  a_ctrl_b_async: assert property (ce && !stop_req && r.func[1] && async_m && b_out
                                   |=> pin_oe[1] && pin_o[1] == $past(r.fs)) // R04
    else $error("line b not receive frame sync in async mode");
  a_ctrl_b_sync: assert property (ce && !stop_req && r.func[1] && !async_m && b_out && r.ctrl[ssp_pkg::CB_B_XTX]
                                  |=> pin_oe[1] && pin_o[1] == $past(tx_q[ssp_pkg::MSB])) // R05
    else $error("line b not extra transmitter in sync mode");
  a_fs_drive: assert property (ce && !stop_req && r.func[2] && fs_int |=> pin_oe[2] && pin_o[2] == $past(r.fs)) // R07
    else $error("frame sync output not internal frame sync");
  a_sck_half: assert property ($changed(r.sck) |=> $stable(r.sck) [*2]) // R11
    else $error("bit clock half shorter than three cycles");
  a_tx_drive: assert property (ce && !stop_req && r.func[5]
                               |=> pin_oe[5] == $past(tx_en) && pin_o[5] == $past(tx_q[ssp_pkg::MSB])) // R13
    else $error("transmit line not driven from shift register");
  a_rx_input: assert property (ce && r.func[4] |=> !pin_oe[4]) // R12
    else $error("receive line driven");
  a_rx_word: assert property (ce && rx_done |=> r.rx_full && r.rxd == $past({rx_q[ssp_pkg::MSB-1:0], din})) // R12
    else $error("received word not captured");

  c_tx_words: cover property (tx_load ##[1:200] tx_load);
  c_rx_word: cover property (ce && rx_done && tx_en);
  c_stop_exit: cover property (stop_req ##1 !stop_req);
  c_async_rx: cover property (ce && rx_done && async_m);
endmodule
`default_nettype wire

// File: core/ssp_pkg.sv
// Shared constants for the synchronous serial port pin block
package ssp_pkg;
  // Pins and word
  localparam int NPIN    = 6;
  localparam int WORD    = 8;
  localparam int MSB     = WORD - 1;
  localparam int ADDR_W  = 12;
  localparam int PIN_CA  = 0;
  localparam int PIN_CB  = 1;
  localparam int PIN_FS  = 2;
  localparam int PIN_SCK = 3;
  localparam int PIN_RXD = 4;
  localparam int PIN_TXD = 5;
  localparam logic [2:0] CNT_LAST = 3'(WORD - 1);
  // Register byte offsets
  localparam logic [11:0] OFF_FUNC = 12'h000;
  localparam logic [11:0] OFF_DIR  = 12'h004;
  localparam logic [11:0] OFF_GPO  = 12'h008;
  localparam logic [11:0] OFF_GPI  = 12'h00C;
  localparam logic [11:0] OFF_CTRL = 12'h010;
  localparam logic [11:0] OFF_DIV  = 12'h014;
  localparam logic [11:0] OFF_TXD  = 12'h018;
  localparam logic [11:0] OFF_RXD  = 12'h01C;
  localparam logic [11:0] OFF_STAT = 12'h020;
  // Control register fields
  localparam int CTL_W      = 11;
  localparam int CB_ASYNC   = 0;
  localparam int CB_SCK_INT = 1;
  localparam int CB_FS_INT  = 2;
  localparam int CB_TX_EN   = 3;
  localparam int CB_RX_EN   = 4;
  localparam int CB_A_OUT   = 5;
  localparam int CB_B_OUT   = 6;
  localparam int CB_A_XTX   = 7;
  localparam int CB_B_XTX   = 8;
  localparam int CB_FLAG_A  = 9;
  localparam int CB_FLAG_B  = 10;
  // Reset values
  localparam logic [5:0]       FUNC_RST = 6'h00;
  localparam logic [5:0]       DIR_RST  = 6'h00;
  localparam logic [CTL_W-1:0] CTRL_RST = 11'h000;
  // Bit clock timing, one system cycle counted as one phase
  localparam int SCK_MIN_PHASES = 6;
  localparam logic [7:0] MIN_HALF = 8'((SCK_MIN_PHASES + 1) / 2);
  localparam logic [7:0] DIV_RST  = MIN_HALF;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: core/ssp_sync.sv
// Two-flop synchroniser for the port pin inputs
`timescale 1ns/1ps
`default_nettype none
module ssp_sync (
  // Clock and control
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  // Data
  input  wire logic [ssp_pkg::NPIN-1:0]   d,
  output logic      [ssp_pkg::NPIN-1:0]   q
);
  typedef struct packed {
    logic [ssp_pkg::NPIN-1:0] meta;
    logic [ssp_pkg::NPIN-1:0] q;
  } ssp_sync_t;

  ssp_sync_t r;
  ssp_sync_t n;

  // First stage feeds only the second
  always_comb begin
    n.meta = d;
    n.q    = r.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign q = r.q;

  a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn) ce [*2] |=> q == $past(d, 2)) // R19
    else $error("synchroniser delay is not two cycles");
endmodule
`default_nettype wire

// File: core/ssp_shifter.sv
// Word shift register for transmit and receive
`timescale 1ns/1ps
`default_nettype none
module ssp_shifter (
  // Clock and control
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  // Load and shift
  input  wire logic                    load,
  input  wire logic [ssp_pkg::MSB:0]   ld_val,
  input  wire logic                    shift,
  input  wire logic                    sin,
  // Contents
  output logic      [ssp_pkg::MSB:0]   q
);
  typedef struct packed {
    logic [ssp_pkg::MSB:0] q;
  } ssp_shift_t;

  ssp_shift_t r;
  ssp_shift_t n;

  // Load beats shift, msb leaves first
  always_comb begin
    n = r;
    if (load) begin
      n.q = ld_val;
    end else if (shift) begin
      n.q = {r.q[ssp_pkg::MSB-1:0], sin};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign q = r.q;

  a_shift_load: assert property (@(posedge aclk) disable iff (!aresetn) ce && load |=> q == $past(ld_val)) // R13
    else $error("shift register did not load");
endmodule
`default_nettype wire

// File: sim/ssp_codec.sv
// Behavioural far-side codec for the serial port
`timescale 1ns/1ps
`default_nettype none
module ssp_codec (
  // Send side
  input  wire logic       send,
  input  wire logic [7:0] word,
  output var  logic       ck,
  output var  logic       fs,
  output var  logic       d,
  output var  logic       busy,
  // Listen side
  input  wire logic       tck,
  input  wire logic       tfs,
  input  wire logic       tdat,
  output var  logic [7:0] heard,
  output var  int         hcnt
);
  logic [7:0] sh;
  initial begin
    ck = 1'b0;
    fs = 1'b0;
    d = 1'b0;
    busy = 1'b0;
    heard = 8'h00;
    hcnt = 0;
  end
  // Clock stands still between frames; odd offset keeps it off the system edges
  always @(posedge send) begin
    busy = 1'b1;
    #3;
    // Data and frame sync move mid-low, so a sampling fall never meets a change
    for (int i = 7; i >= 0; i--) begin
      d = word[i];
      fs = (i == 7);
      #20 ck = 1'b1;
      #40 ck = 1'b0;
      #20;
    end
    // Released data line shows the inverse of the last bit
    d = ~d;
    busy = 1'b0;
  end
  // Frame starts at a falling edge with frame sync high, MSB first
  always @(negedge tck) begin
    if (tfs === 1'b1) begin
      sh = {7'h00, tdat};
      for (int k = 1; k < 8; k++) begin
        @(negedge tck);
        sh = {sh[6:0], tdat};
      end
      heard = sh;
      hcnt++;
    end
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the serial port pin block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk, aresetn, ce, stop_req;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [5:0]  pin_i, pin_o, pin_oe, tb_v, ext;
  logic        asy, snd, cck, cfs, cd, cbusy;
  logic [7:0]  cword, heard;
  int          hcnt, err_total, samples_checked;

  ssp_port ssp_port_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .stop_req(stop_req),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
  ssp_codec ssp_codec_inst (.send(snd), .word(cword), .ck(cck), .fs(cfs), .d(cd),
    .busy(cbusy), .tck(pin_i[3]), .tfs(pin_i[2]), .tdat(pin_i[5]), .heard(heard),
    .hcnt(hcnt));

  // Codec uses the async receive lines or the shared sync lines
  always_comb begin
    ext = tb_v;
    ext[4] = cd;
    if (asy) begin
      ext[0] = cck;
      ext[1] = cfs;
    end else begin
      ext[3] = cck;
      ext[2] = cfs;
    end
  end
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic ck_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: value %h, want %h", $time, g, e);
    end
  endtask

  task automatic ck_pin(input logic [5:0] g, input logic [5:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: pins %h, want %h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    bit ad;
    bit dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && dd));
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic frame(input logic [7:0] w);
    cword <= w;
    snd <= 1'b1;
    @(posedge aclk);
    snd <= 1'b0;
    @(posedge aclk);
    while (cbusy) @(posedge aclk);
    repeat (8) @(posedge aclk);
  endtask

  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, stop_req} = '0;
    {asy, snd, cword, tb_v} = '0;
    err_total = 0;
    samples_checked = 0;
    ce = 1'b1;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ck_pin(pin_oe, 6'h00);
    axr(ssp_pkg::OFF_FUNC);
    ck_val(rv, 32'h0000_0000);
    axr(ssp_pkg::OFF_DIR);
    ck_val(rv, 32'h0000_0000);
    axr(ssp_pkg::OFF_DIV);
    ck_val(rv, 32'h0000_0003);
    axr(12'h0FC);
    ck_val({30'h0, rs}, {30'h0, ssp_pkg::RESP_SLVERR});
    // General-purpose outputs, then stop releases them
    axw(ssp_pkg::OFF_DIR, 32'h0000_003F);
    ck_val({30'h0, rs}, {30'h0, ssp_pkg::RESP_OKAY});
    axw(12'h0FC, 32'h0000_0000);
    ck_val({30'h0, rs}, {30'h0, ssp_pkg::RESP_SLVERR});
    axw(ssp_pkg::OFF_GPO, 32'h0000_002A);
    repeat (3) @(posedge aclk);
    ck_pin(pin_oe, 6'h3F);
    ck_pin(pin_o, 6'h2A);
    // Enable low holds the pins even while stop is asked for
    ce <= 1'b0;
    stop_req <= 1'b1;
    repeat (3) @(posedge aclk);
    ck_pin(pin_oe, 6'h3F);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    ck_pin(pin_oe, 6'h00);
    stop_req <= 1'b0;
    repeat (2) @(posedge aclk);
    ck_pin(pin_oe, 6'h3F);
    // General-purpose inputs through the synchroniser
    axw(ssp_pkg::OFF_DIR, 32'h0000_0000);
    tb_v <= 6'h23;
    repeat (4) @(posedge aclk);
    axr(ssp_pkg::OFF_GPI);
    ck_val(rv, 32'h0000_0023);
    // Sync receive on external bit clock and frame sync
    axw(ssp_pkg::OFF_FUNC, 32'h0000_001C);
    axw(ssp_pkg::OFF_CTRL, 32'h0000_0010);
    frame(8'hA5);
    axr(ssp_pkg::OFF_STAT);
    ck_val(rv & 32'h2, 32'h0000_0002);
    axr(ssp_pkg::OFF_RXD);
    ck_val(rv, 32'h0000_00A5);
    // Async full duplex: internal tx clock and sync, rx on control lines
    asy <= 1'b1;
    axw(ssp_pkg::OFF_FUNC, 32'h0000_003F);
    axw(ssp_pkg::OFF_TXD, 32'h0000_003C);
    axw(ssp_pkg::OFF_CTRL, 32'h0000_001F);
    frame(8'h96);
    ck_pin(pin_oe, 6'h2C);
    axr(ssp_pkg::OFF_RXD);
    ck_val(rv, 32'h0000_0096);
    repeat (60) @(posedge aclk);
    ck_val({24'h0, heard}, 32'h0000_003C);
    // Sync mode flags on both control lines
    asy <= 1'b0;
    axw(ssp_pkg::OFF_FUNC, 32'h0000_0003);
    axw(ssp_pkg::OFF_CTRL, 32'h0000_0260);
    repeat (3) @(posedge aclk);
    ck_pin(pin_oe & 6'h03, 6'h03);
    ck_pin(pin_o & 6'h03, 6'h01);
    axw(ssp_pkg::OFF_CTRL, 32'h0000_0460);
    repeat (2) @(posedge aclk);
    ck_pin(pin_o & 6'h03, 6'h02);
    // Line b carries the transmit word, line a its flag
    axw(ssp_pkg::OFF_CTRL, 32'h0000_0160);
    repeat (2) @(posedge aclk);
    ck_pin(pin_o & 6'h01, 6'h00);
    // Async mode with both control lines driven from inside
    axw(ssp_pkg::OFF_CTRL, 32'h0000_0061);
    repeat (2) @(posedge aclk);
    ck_pin(pin_oe & 6'h03, 6'h03);
    end_sim();
  end
endmodule
`default_nettype wire
